// >>> logic/sa_adc_seq.sv
// Track, hold and conversion sequencer of a two-input serial converter
`timescale 1ns/100ps

// Operation
// RQ1 - Conversion resolves in twelve conversion clocks
// RQ2 - Internal clock: track at address eighth rise
// RQ3 - Internal clock: hold at acknowledge falling edge
// RQ4 - Internal clock: convert, hold clock line low
// RQ5 - External clock: track at read bit rise
// RQ6 - External clock: hold second result rise, convert
// RQ7 - Acquisition 1.5 or 2 serial periods; code tracks 1.5 internal, 3 external (read bit rise to second result rise)
// RQ8 - Single-ended: selected input against ground
// RQ9 - Differential: selected pair, plus minus minus
// RQ10 - Unipolar differential negative gives zero code
// RQ11 - Straight binary unipolar, two's complement bipolar
// RQ12 - Single-ended forces unipolar, polarity ignored
// RQ13 - Master starts transfers, drives serial clock
// RQ14 - Written byte MSB picks setup or config
// RQ15 - Address LSB gives transfer direction
// RQ16 - Setup bit picks internal or external clock
// RQ17 - Master waits while clock line stretched
module sa_adc_seq
    import sa_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h2A,  // Arbitrary value
    parameter int         STEP_DIV   = INT_CLK_DIV
)
(
    input  wire logic        clock_i,           // System clock 50 MHz
    input  wire logic        rstn_i,            // Async reset, active low
    input  wire logic        scl_clk_i,         // Serial clock as clock
    input  wire logic        scl_i,             // Serial clock level
    input  wire logic        sda_i,             // Serial data level
    output logic             sda_o,             // Data drive value
    output logic             sda_oe_o,          // Data drive enable
    output logic             scl_o,             // Clock drive value
    output logic             scl_oe_o,          // Clock stretch enable
    input  wire logic [11:0] analog_input_a_i,  // First input level
    input  wire logic [11:0] analog_input_b_i,  // Second input level
    output logic             track_o,           // Sampler tracking
    output logic             busy_o,            // Conversion running
    output logic      [11:0] result_o,          // Last result code
    output logic             result_valid_o,    // Result pulse
    output logic             ext_clock_o,       // External clock chosen
    output logic             polarity_o,        // Bipolar chosen
    output logic             input_mode_o,      // Single-ended chosen
    output logic             channel_o          // Channel select
);
    sa_link_if link ();

    // Pin synchronisers and edge history
    logic [1:0]  scl_sy_q, scl_sy_d, sda_sy_q, sda_sy_d;
    logic        scl_old_q, sda_old_q;
    logic [11:0] ain_a1_q, ain_a2_q, ain_b1_q, ain_b2_q;
    logic [1:0]  byte_sy_q, byte_sy_d;
    logic        byte_old_q;
    // Protocol and sequencer state
    sa_state_t   state_q, state_d;
    logic        in_frame_q, in_frame_d;
    logic [3:0]  bit_q, bit_d;
    logic [1:0]  byte_idx_q, byte_idx_d;
    logic [7:0]  addr_q, addr_d;
    logic        addr_ok_q, addr_ok_d;
    logic        rd_q, rd_d;
    logic        ack_q, ack_d;
    logic        frame_tgl_q, frame_tgl_d;
    logic        ext_q, ext_d, pol_q, pol_d, mode_q, mode_d, cs_q, cs_d;
    logic        bip_q, bip_d;
    logic [11:0] target_q, target_d;
    logic [7:0]  div_q, div_d;
    logic [11:0] res_q, res_d;
    logic        resv_q, resv_d;
    // Combinational helpers
    logic        scl_rise, scl_fall, start_c, stop_c, byte_ev;
    logic [7:0]  addr_full;
    logic        sar_start, sar_step, sar_busy, sar_done;
    logic [11:0] sar_code, pos_c, neg_c, sel_c;
    logic [12:0] diff_c;

    sa_link_rx u_link (
        .scl_clk_i (scl_clk_i),
        .rstn_i    (rstn_i),
        .sda_i     (sda_i),
        .link      (link.lnk)
    );

    sa_sar_core #(.WIDTH(SAR_BITS)) u_sar (
        .clock_i  (clock_i),
        .rstn_i   (rstn_i),
        .start_i  (sar_start),
        .step_i   (sar_step),
        .target_i (target_q),
        .busy_o   (sar_busy),
        .done_o   (sar_done),
        .code_o   (sar_code)
    );

    // Bus events from the second synchroniser stage onward
    assign scl_sy_d  = {scl_sy_q[0], scl_i};
    assign sda_sy_d  = {sda_sy_q[0], sda_i};
    assign byte_sy_d = {byte_sy_q[0], link.byte_tgl};
    assign scl_rise  = scl_sy_q[1] & ~scl_old_q;
    assign scl_fall  = ~scl_sy_q[1] & scl_old_q;
    assign start_c   = scl_sy_q[1] & scl_old_q & sda_old_q & ~sda_sy_q[1];
    assign stop_c    = scl_sy_q[1] & scl_old_q & ~sda_old_q & sda_sy_q[1];
    assign byte_ev   = byte_sy_q[1] ^ byte_old_q;
    assign addr_full = {addr_q[6:0], sda_sy_q[1]};

    // Input routing and output coding of the held sample
    always_comb
    begin
        pos_c  = cs_q ? ain_b2_q : ain_a2_q;  // RQ9
        neg_c  = cs_q ? ain_a2_q : ain_b2_q;  // RQ9
        sel_c  = cs_q ? ain_b2_q : ain_a2_q;  // RQ8
        diff_c = {1'b0, pos_c} - {1'b0, neg_c};
        bip_d  = bip_q;
        if (mode_q)
            target_d = sel_c;  // RQ8
        else if (pol_q)
            target_d = diff_c[12:1] ^ BIP_OFFSET;  // RQ11
        else if (diff_c[12])
            target_d = 12'h000;  // RQ10
        else
            target_d = diff_c[11:0];
        if (!sar_start)
            target_d = target_q;
        else
            bip_d = pol_q & ~mode_q;  // RQ12
    end

    // Serial protocol, setup capture and track/hold sequencing
    always_comb
    begin
        state_d     = state_q;
        in_frame_d  = in_frame_q;
        bit_d       = bit_q;
        byte_idx_d  = byte_idx_q;
        addr_d      = addr_q;
        addr_ok_d   = addr_ok_q;
        rd_d        = rd_q;
        ack_d       = ack_q;
        frame_tgl_d = frame_tgl_q;
        ext_d       = ext_q;
        pol_d       = pol_q;
        mode_d      = mode_q;
        cs_d        = cs_q;
        div_d       = div_q;
        res_d       = res_q;
        resv_d      = 1'b0;
        sar_start   = 1'b0;
        sar_step    = 1'b0;
        // Frame boundaries and bit slots
        if (start_c || stop_c)
        begin
            in_frame_d  = start_c;
            frame_tgl_d = frame_tgl_q ^ start_c;
            bit_d       = 4'h0;
            byte_idx_d  = 2'd0;
            addr_ok_d   = 1'b0;
            ack_d       = 1'b0;
        end
        else if (in_frame_q && scl_rise)
        begin
            bit_d = (bit_q == BIT_ACK) ? 4'h1 : bit_q + 4'h1;
            if (byte_idx_q == 2'd0 && bit_q < BIT_ADDR_LAST)
                addr_d = addr_full;
            if (byte_idx_q == 2'd0 && bit_q == BIT_ADDR_LAST - 4'h1)
            begin
                addr_ok_d = (addr_full[7:1] == SLAVE_ADDR);
                rd_d      = addr_full[0];  // RQ15
            end
        end
        else if (in_frame_q && scl_fall)
        begin
            if (bit_q == BIT_ADDR_LAST)
                ack_d = addr_ok_q & (byte_idx_q == 2'd0 | ~rd_q);
            if (bit_q == BIT_ACK)
            begin
                ack_d = 1'b0;
                if (byte_idx_q != 2'd3)
                    byte_idx_d = byte_idx_q + 2'd1;
            end
        end
        // Written bytes: setup when MSB set, else configuration
        if (byte_ev && addr_ok_q && !rd_q && byte_idx_q != 2'd0)
        begin
            if (link.byte_data[BYTE_KIND_BIT])  // RQ14
            begin
                ext_d = link.byte_data[SETUP_CLK_BIT];  // RQ16
                pol_d = link.byte_data[SETUP_POL_BIT];
                if (!link.byte_data[SETUP_RST_BIT])
                begin
                    mode_d = MODE_RST;
                    cs_d   = CS_RST;
                end
            end
            else
            begin
                mode_d = link.byte_data[CFG_MODE_BIT];
                cs_d   = link.byte_data[CFG_CS_BIT];
            end
        end
        // Track and hold sequencing
        case (state_q)
            SA_IDLE:
            begin
                if (in_frame_q && scl_rise && byte_idx_q == 2'd0
                    && bit_q == BIT_ADDR_LAST - 4'h1
                    && addr_full[7:1] == SLAVE_ADDR && addr_full[0])
                    state_d = ext_q ? SA_TRACK_E : SA_TRACK_I;  // RQ2 RQ5
            end
            SA_TRACK_I:
            begin
                if (start_c || stop_c)
                    state_d = SA_IDLE;
                else if (scl_fall && bit_q == BIT_ACK)  // RQ3 RQ7
                begin
                    state_d   = SA_CONV_I;
                    sar_start = 1'b1;
                    div_d     = 8'd0;
                end
            end
            SA_CONV_I:
            begin
                div_d = (div_q == 8'(STEP_DIV - 1)) ? 8'd0 : div_q + 8'd1;
                sar_step = (div_q == 8'(STEP_DIV - 1));  // RQ4
            end
            SA_TRACK_E:
            begin
                if (start_c || stop_c)
                    state_d = SA_IDLE;
                else if (scl_rise && byte_idx_q == 2'd1
                         && bit_q == BIT_EXT_HOLD - 4'h1)  // RQ6 RQ7
                begin
                    state_d   = SA_CONV_E;
                    sar_start = 1'b1;
                end
            end
            SA_CONV_E:
            begin
                sar_step = scl_rise;  // RQ6
                if (start_c || stop_c)
                    state_d = SA_IDLE;
            end
            default:
                state_d = SA_IDLE;
        endcase
        // Finished conversion returns to idle and releases the clock
        if (sar_done && state_q != SA_IDLE)
        begin
            state_d = SA_IDLE;
            res_d   = bip_q ? (sar_code ^ BIP_OFFSET) : sar_code;  // RQ11
            resv_d  = 1'b1;
        end
    end

    // System-domain registers
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scl_sy_q    <= 2'b11;
            sda_sy_q    <= 2'b11;
            scl_old_q   <= 1'b1;
            sda_old_q   <= 1'b1;
            byte_sy_q   <= 2'b00;
            byte_old_q  <= 1'b0;
            ain_a1_q    <= 12'h000;
            ain_a2_q    <= 12'h000;
            ain_b1_q    <= 12'h000;
            ain_b2_q    <= 12'h000;
            state_q     <= SA_IDLE;
            in_frame_q  <= 1'b0;
            bit_q       <= 4'h0;
            byte_idx_q  <= 2'd0;
            addr_q      <= 8'h00;
            addr_ok_q   <= 1'b0;
            rd_q        <= 1'b0;
            ack_q       <= 1'b0;
            frame_tgl_q <= 1'b0;
            ext_q       <= EXT_CLK_RST;
            pol_q       <= POL_RST;
            mode_q      <= MODE_RST;
            cs_q        <= CS_RST;
            bip_q       <= 1'b0;
            target_q    <= 12'h000;
            div_q       <= 8'd0;
            res_q       <= 12'h000;
            resv_q      <= 1'b0;
        end
        else
        begin
            scl_sy_q    <= scl_sy_d;
            sda_sy_q    <= sda_sy_d;
            scl_old_q   <= scl_sy_q[1];
            sda_old_q   <= sda_sy_q[1];
            byte_sy_q   <= byte_sy_d;
            byte_old_q  <= byte_sy_q[1];
            ain_a1_q    <= analog_input_a_i;
            ain_a2_q    <= ain_a1_q;
            ain_b1_q    <= analog_input_b_i;
            ain_b2_q    <= ain_b1_q;
            state_q     <= state_d;
            in_frame_q  <= in_frame_d;
            bit_q       <= bit_d;
            byte_idx_q  <= byte_idx_d;
            addr_q      <= addr_d;
            addr_ok_q   <= addr_ok_d;
            rd_q        <= rd_d;
            ack_q       <= ack_d;
            frame_tgl_q <= frame_tgl_d;
            ext_q       <= ext_d;
            pol_q       <= pol_d;
            mode_q      <= mode_d;
            cs_q        <= cs_d;
            bip_q       <= bip_d;
            target_q    <= target_d;
            div_q       <= div_d;
            res_q       <= res_d;
            resv_q      <= resv_d;
        end
    end

    // Pin drives and status outputs
    assign link.frame_tgl = frame_tgl_q;
    assign sda_o          = 1'b0;
    assign sda_oe_o       = ack_q;
    assign scl_o          = 1'b0;
    assign scl_oe_o       = (state_q == SA_CONV_I);  // RQ4 RQ17
    assign track_o        = (state_q == SA_TRACK_I)
                          | (state_q == SA_TRACK_E);
    assign busy_o         = sar_busy;
    assign result_o       = res_q;
    assign result_valid_o = resv_q;
    assign ext_clock_o    = ext_q;
    assign polarity_o     = pol_q;
    assign input_mode_o   = mode_q;
    assign channel_o      = cs_q;
endmodule : sa_adc_seq

// >>> logic/sa_pkg.sv
// Shared constants for the sample and convert sequencer
package sa_pkg;
    // Result width and successive-approximation length
    localparam int          SAR_BITS      = 12;
    localparam logic [11:0] BIP_OFFSET    = 12'h0800;
    // Written byte layout
    localparam int          BYTE_KIND_BIT = 7;
    localparam int          SETUP_CLK_BIT = 3;
    localparam int          SETUP_POL_BIT = 2;
    localparam int          SETUP_RST_BIT = 1;
    localparam int          CFG_MODE_BIT  = 0;
    localparam int          CFG_CS_BIT    = 1;
    // Reset values of the stored fields
    localparam logic        EXT_CLK_RST   = 1'b0;
    localparam logic        POL_RST       = 1'b0;
    localparam logic        MODE_RST      = 1'b1;
    localparam logic        CS_RST        = 1'b0;
    // Serial bit positions within one nine-clock byte slot
    localparam logic [3:0]  BIT_ADDR_LAST = 4'h8;
    localparam logic [3:0]  BIT_ACK       = 4'h9;
    localparam logic [3:0]  BIT_EXT_HOLD  = 4'h2;
    // Acquisition length in half serial periods
    localparam int          ACQ_HALF_INT  = 3;
    localparam int          ACQ_HALF_EXT  = 4;
    // Internal conversion clock divider from the system clock
    localparam int          INT_CLK_DIV   = 4;

    // Track and hold sequencer states
    typedef enum logic [4:0] {
        SA_IDLE    = 5'b00001,
        SA_TRACK_I = 5'b00010,
        SA_CONV_I  = 5'b00100,
        SA_TRACK_E = 5'b01000,
        SA_CONV_E  = 5'b10000
    } sa_state_t;
endpackage : sa_pkg

// >>> logic/sa_link_if.sv
// Carrier between system domain and serial-clock domain
`timescale 1ns/100ps
interface sa_link_if;
    logic       frame_tgl;
    logic       byte_tgl;
    logic [7:0] byte_data;

    modport sys (output frame_tgl, input byte_tgl, input byte_data);
    modport lnk (input frame_tgl, output byte_tgl, output byte_data);
endinterface : sa_link_if

// >>> logic/sa_link_rx.sv
// Byte receiver clocked by the serial clock itself
`timescale 1ns/100ps
module sa_link_rx
    import sa_pkg::*;
(
    input  wire logic scl_clk_i,   // Serial clock as a clock
    input  wire logic rstn_i,      // Async reset, active low
    input  wire logic sda_i,       // Serial data pin
    sa_link_if.lnk    link         // Frame and byte crossing
);
    logic [1:0] frm_sync_q, frm_sync_d;
    logic       frm_seen_q, frm_seen_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] data_q, data_d;
    logic       tgl_q, tgl_d;

    // Next values: new frame lands on third rise, shift, hand-over
    always_comb
    begin
        frm_sync_d = {frm_sync_q[0], link.frame_tgl};
        frm_seen_d = frm_sync_q[1];
        sh_d       = {sh_q[6:0], sda_i};
        data_d     = data_q;
        tgl_d      = tgl_q;
        if (frm_sync_q[1] != frm_seen_q)
            cnt_d = 4'h3;
        else if (cnt_q == BIT_ACK)
            cnt_d = 4'h1;
        else
            cnt_d = cnt_q + 4'h1;
        if (cnt_d == BIT_ACK)
            sh_d = sh_q;
        if (cnt_d == BIT_ADDR_LAST)
        begin
            data_d = sh_d;
            tgl_d  = ~tgl_q;
        end
    end

    // Link-side registers
    always_ff @(posedge scl_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            frm_sync_q <= 2'b00;
            frm_seen_q <= 1'b0;
            cnt_q      <= 4'h0;
            sh_q       <= 8'h00;
            data_q     <= 8'h00;
            tgl_q      <= 1'b0;
        end
        else
        begin
            frm_sync_q <= frm_sync_d;
            frm_seen_q <= frm_seen_d;
            cnt_q      <= cnt_d;
            sh_q       <= sh_d;
            data_q     <= data_d;
            tgl_q      <= tgl_d;
        end
    end

    assign link.byte_tgl  = tgl_q;
    assign link.byte_data = data_q;
endmodule : sa_link_rx

// >>> logic/sa_sar_core.sv
// Successive-approximation engine, one bit per step
`timescale 1ns/100ps
module sa_sar_core
    import sa_pkg::*;
#(
    parameter int WIDTH = SAR_BITS
)
(
    input  wire logic             clock_i,   // System clock
    input  wire logic             rstn_i,    // Async reset, active low
    input  wire logic             start_i,   // Begin on held sample
    input  wire logic             step_i,    // One conversion clock
    input  wire logic [WIDTH-1:0] target_i,  // Held sample code
    output logic                  busy_o,    // Conversion running
    output logic                  done_o,    // One-cycle finish pulse
    output logic      [WIDTH-1:0] code_o     // Resolved code
);
    logic [WIDTH-1:0] trial_q, trial_d;
    logic [WIDTH-1:0] mask_q, mask_d;
    logic [WIDTH-1:0] code_q, code_d;
    logic             busy_q, busy_d;
    logic             done_q, done_d;
    logic [WIDTH-1:0] kept;

    // Decide one bit per step, MSB first
    always_comb
    begin
        kept    = (trial_q <= target_i) ? trial_q : (trial_q & ~mask_q);
        trial_d = trial_q;
        mask_d  = mask_q;
        code_d  = code_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        if (start_i)
        begin
            mask_d  = {1'b1, {(WIDTH-1){1'b0}}};
            trial_d = {1'b1, {(WIDTH-1){1'b0}}};
            busy_d  = 1'b1;
        end
        else if (busy_q && step_i)
        begin
            mask_d  = mask_q >> 1;
            trial_d = kept | (mask_q >> 1);
            if (mask_q[0])  // RQ1
            begin
                code_d = kept;
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    // Engine registers
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            trial_q <= '0;
            mask_q  <= '0;
            code_q  <= '0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            trial_q <= trial_d;
            mask_q  <= mask_d;
            code_q  <= code_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign code_o = code_q;
endmodule : sa_sar_core

// >>> bench/sa_adc_seq_props.sv
// Port timing checker of the sequencer
`timescale 1ns/100ps
module sa_adc_seq_props
    import sa_pkg::*;
#(
    parameter int STEP_DIV = INT_CLK_DIV
)
(
    input wire logic        clock_i,        // System clock
    input wire logic        rstn_i,         // Reset, active low
    input wire logic        sda_o,          // Data drive value
    input wire logic        scl_o,          // Clock drive value
    input wire logic        scl_oe_o,       // Clock stretch
    input wire logic        track_o,        // Tracking
    input wire logic        busy_o,         // Converting
    input wire logic [11:0] result_o,       // Result
    input wire logic        result_valid_o, // Result pulse
    input wire logic        ext_clock_o     // External clock
);
    localparam int STR_LO = 12 * STEP_DIV;
    localparam int STR_HI = 12 * STEP_DIV + 4;
    logic [9:0] str_q, str_d;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // Stretch length
    always_comb str_d = scl_oe_o ? str_q + 10'h001 : 10'h000;
    always_ff @(posedge clock_i or negedge rstn_i)
        if (!rstn_i)
            str_q <= 10'h000;
        else
            str_q <= str_d;

    AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    AST_STRETCH_LEN: assert property ($fell(scl_oe_o) |->
        (str_q >= STR_LO && str_q <= STR_HI)) else $error("stretch length");
    AST_STRETCH_BUSY: assert property ($rose(scl_oe_o) |-> ##[0:2] busy_o)
        else $error("stretch not busy");
    AST_STRETCH_INT: assert property (scl_oe_o |-> !ext_clock_o)
        else $error("stretch in ext mode");
    AST_TRACK_BUSY: assert property (track_o |-> !busy_o)
        else $error("track while busy");
    AST_HOLD_STRETCH: assert property ($fell(track_o) && !ext_clock_o
        |-> ##[0:4] scl_oe_o) else $error("no stretch after hold");
    AST_VALID_PULSE: assert property (result_valid_o |=> !result_valid_o)
        else $error("result pulse too long");
    AST_BUSY_DONE: assert property ($fell(busy_o) |-> ##[0:2] result_valid_o)
        else $error("busy ended, no result");
    AST_RESULT_HOLD: assert property ($changed(result_o) |->
        ##[0:1] (result_valid_o || $past(result_valid_o)))
        else $error("silent result change");
endmodule : sa_adc_seq_props

bind sa_adc_seq sa_adc_seq_props #(.STEP_DIV(STEP_DIV)) u_props (
    .clock_i(clock_i), .rstn_i(rstn_i), .sda_o(sda_o), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .track_o(track_o), .busy_o(busy_o),
    .result_o(result_o), .result_valid_o(result_valid_o),
    .ext_clock_o(ext_clock_o));

// >>> bench/sa_bus_master.sv
// Two-wire bus master model
`timescale 1ns/100ps
module sa_bus_master #(
    parameter time HALF = 150
)
(
    output logic     scl_m_o, // Clock, low pulls line
    output logic     sda_m_o, // Data, low pulls line
    input wire logic scl_w_i, // Resolved clock line
    input wire logic sda_w_i  // Resolved data line
);
    initial
    begin
        scl_m_o = 1'b1;
        sda_m_o = 1'b1;
    end

    // Release clock, wait out stretch
    task automatic rise;
        int n = 0;
        scl_m_o = 1'b1;
        #1;
        while (!scl_w_i && n < 20000)
        begin
            #5;
            n++;
        end
    endtask : rise

    // Clock low, then data hold
    task automatic fall;
        scl_m_o = 1'b0;
        #40;
    endtask : fall

    task automatic bit_out(input logic b);
        sda_m_o = b;
        #HALF;
        rise();
        #HALF;
        fall();
    endtask : bit_out

    task automatic bit_in(output logic b);
        sda_m_o = 1'b1;
        #HALF;
        rise();
        b = sda_w_i;
        #HALF;
        fall();
    endtask : bit_in

    // Master opens transfers, drives clock
    task automatic start;
        sda_m_o = 1'b1;
        #HALF;
        rise();
        #HALF;
        sda_m_o = 1'b0;
        #HALF;
        fall();
    endtask : start

    task automatic stop;
        sda_m_o = 1'b0;
        #HALF;
        rise();
        #HALF;
        sda_m_o = 1'b1;
    endtask : stop

    // Byte out, MSB first
    task automatic wr(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(ack);
    endtask : wr

    task automatic rd(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(last);
    endtask : rd
endmodule : sa_bus_master

// >>> bench/sa_adc_seq_test.sv
// Self-checking bench of the sequencer
`timescale 1ns/100ps
module sa_adc_seq_test;
    import sa_pkg::*;

    typedef struct packed {
        logic [7:0]  setup;
        logic [7:0]  cfg;
        logic [11:0] a;
        logic [11:0] b;
        logic [11:0] res;
    } sa_row_t;

    localparam logic [6:0] ADDR = 7'h2A; // Arbitrary value
    localparam sa_row_t    ROWS [10] = '{
        '{8'h82, 8'h01, 12'h5A3, 12'h123, 12'h5A3},
        '{8'h82, 8'h03, 12'h5A3, 12'h123, 12'h123},
        '{8'h86, 8'h01, 12'h5A3, 12'h123, 12'h5A3},
        '{8'h82, 8'h00, 12'h700, 12'h200, 12'h500},
        '{8'h82, 8'h00, 12'h200, 12'h700, 12'h000},
        '{8'h82, 8'h02, 12'h200, 12'h700, 12'h500},
        '{8'h86, 8'h00, 12'h800, 12'h400, 12'h200},
        '{8'h86, 8'h00, 12'h400, 12'h800, 12'hE00},
        '{8'h8A, 8'h01, 12'h5A3, 12'h123, 12'h5A3},
        '{8'h8E, 8'h00, 12'h000, 12'hFFE, 12'h801}};

    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [11:0] ain_a = 12'h000;
    logic [11:0] ain_b = 12'h000;
    logic        scl_m, sda_m, sda_o, sda_oe_o, scl_o, scl_oe_o;
    logic        track_o, busy_o, result_valid_o, ack_any, trk_p, str_p;
    logic        ext_clock_o, polarity_o, input_mode_o, channel_o;
    logic [11:0] result_o, res_seen;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_track = 0, n_str = 0, n_valid = 0;
    // Open-drain lines with pull-ups
    wire         scl_w = scl_m & ~scl_oe_o;
    wire         sda_w = sda_m & ~sda_oe_o;

    always #10 clock_i = ~clock_i;

    sa_adc_seq #(.SLAVE_ADDR(ADDR), .STEP_DIV(INT_CLK_DIV)) dut_u (
        .clock_i(clock_i), .rstn_i(rstn_i), .scl_clk_i(scl_w),
        .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .analog_input_a_i(ain_a),
        .analog_input_b_i(ain_b), .track_o(track_o), .busy_o(busy_o),
        .result_o(result_o), .result_valid_o(result_valid_o),
        .ext_clock_o(ext_clock_o), .polarity_o(polarity_o),
        .input_mode_o(input_mode_o), .channel_o(channel_o));

    sa_bus_master mst (.scl_m_o(scl_m), .sda_m_o(sda_m), .scl_w_i(scl_w),
        .sda_w_i(sda_w));

    // Count starts, catch results
    always @(posedge clock_i)
    begin
        trk_p <= track_o;
        str_p <= scl_oe_o;
        if (track_o && !trk_p)
            n_track++;
        if (scl_oe_o && !str_p)
            n_str++;
        if (result_valid_o)
        begin
            n_valid++;
            res_seen = result_o;
        end
    end

    task automatic chk(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Fields: ext, bipolar, single-ended, channel
    task automatic chk_cfg(input logic [3:0] exp);
        chk("fields", {8'h00, ext_clock_o, polarity_o, input_mode_o,
            channel_o}, {8'h00, exp});
    endtask : chk_cfg

    task automatic put(input logic [7:0] d);
        logic ak;
        mst.wr(d, ak);
        ack_any = ack_any | ak;
    endtask : put

    task automatic run_row(input sa_row_t r);
        int         t0, v0, s0;
        logic [7:0] d;
        @(posedge clock_i);
        ain_a <= r.a;
        ain_b <= r.b;
        ack_any = 1'b0;
        t0 = n_track;
        v0 = n_valid;
        s0 = n_str;
        mst.start();
        put({ADDR, 1'b0});
        put(r.setup);
        put(r.cfg);
        mst.start();
        put({ADDR, 1'b1});
        mst.rd(1'b0, d);
        mst.rd(1'b1, d);
        mst.stop();
        repeat (4) @(posedge clock_i);
        chk("ack", 12'(ack_any), 12'h000);
        chk("result", res_seen, r.res);
        chk("results", 12'(n_valid - v0), 12'h001);
        chk("track", 12'(n_track - t0), 12'h001);
        chk("stretch", 12'(n_str - s0), 12'(!r.setup[3]));
        chk_cfg({r.setup[3:2], r.cfg[0], r.cfg[1]});
    endtask : run_row

    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    initial
    begin
        #1_000_000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        int   t0;
        logic ak;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        chk_cfg(4'b0010);
        chk("reset result", result_o, 12'h000);
        foreach (ROWS[i])
            run_row(ROWS[i]);
        // Second reset in mid-run
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        chk_cfg(4'b0010);
        // Setup reset bit restores config reset values
        ack_any = 1'b0;
        t0 = n_track;
        mst.start();
        put({ADDR, 1'b0});
        put(8'h02);
        put(8'h84);
        mst.stop();
        repeat (8) @(posedge clock_i);
        chk_cfg(4'b0110);
        // Foreign address, then write-only address
        mst.start();
        mst.wr({ADDR ^ 7'h01, 1'b1}, ak);
        mst.stop();
        chk("nack", 12'(ak), 12'h001);
        mst.start();
        put({ADDR, 1'b0});
        mst.stop();
        repeat (8) @(posedge clock_i);
        chk("ack", 12'(ack_any), 12'h000);
        chk("track", 12'(n_track - t0), 12'h000);
        wrap_up();
    end
endmodule : sa_adc_seq_test
